/* logic/rdsd_pkg.sv */
// Constants shared by the relay driver serial and diagnosis logic.
// Assumes a 50 MHz system clock; timing counts derive from that rate.
package rdsd_pkg;

   localparam int NUM_CH     = 8;
   localparam int WORD_W     = 16;
   localparam int MODE_W     = 2;

   // Frame length acceptance
   localparam int FRAME_MULT     = 8;
   localparam int FRAME_MIN_BITS = 16;
   localparam int FRAME_MIN_MULT = FRAME_MIN_BITS / FRAME_MULT;

   // Reset values: everything reads as ones after power-on
   localparam logic [15:0] IN_WORD_RESET = 16'hFFFF;
   localparam logic [15:0] DIAG_RESET    = 16'hFFFF;
   localparam logic        TER_RESET     = 1'h1;

   // Per channel mode field encodings
   localparam logic [1:0] MODE_STANDBY = 2'h0;
   localparam logic [1:0] MODE_INPUT   = 2'h1;
   localparam logic [1:0] MODE_ON      = 2'h2;
   localparam logic [1:0] MODE_OFF     = 2'h3;

   // Diagnosis word layout: per channel pair, open load above fault
   localparam int DIAG_FAULT_POS = 0;
   localparam int DIAG_OL_POS    = 1;

   // Timing
   localparam int CLK_PERIOD_NS        = 20;
   localparam int OPEN_LOAD_DELAY_MIN_NS   = 30_000;
   localparam int OPEN_LOAD_DELAY_MAX_NS   = 200_000;
   localparam int OVERLOAD_OFF_DELAY_MIN_NS = 3_000;
   localparam int OVERLOAD_OFF_DELAY_MAX_NS = 50_000;
   localparam int OPEN_LOAD_DELAY_CYC =
      (OPEN_LOAD_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OVERLOAD_OFF_DELAY_CYC =
      (OVERLOAD_OFF_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_CNT_W = 12;

endpackage

/* logic/rdsd_spi_diag.sv */
// Serial slave and latched per channel diagnosis of an eight channel
// low-side relay driver.
// Assumes the master keeps the serial clock low around chip select edges
// and leaves at least three system clocks from chip select falling to the
// first rising serial clock edge.
// Delay parameters must stay below the range of the delay counters.
//
// Operation
// RQ1: Sticky protection fault flag per channel
// RQ2: Sticky open-load flag per channel
// RQ3: Standby clears both flags of channel
// RQ4: Open-load detection only while commanded off
// RQ5: Open-load flag after persistence delay
// RQ6: Overtemperature sets fault, switches channel off
// RQ7: Overload switches off after delay, sets fault
// RQ8: Chip select high: ignore clock, release output
// RQ9: Sample input on falling, shift on rising
// RQ10: Words travel most significant bit first
// RQ11: Chip select falling loads diagnosis snapshot
// RQ12: Before first rising edge, output error OR input
// RQ13: Any reset sets transfer error flag
// RQ14: Commit only on multiple-of-8, at least 16
// RQ15: Master keeps clock low at select edges
// RQ16: Master frames access with select edges
// RQ17: One bit in per clock, chained through
// RQ18: Chain master shifts total of all lengths
// RQ19: Serial registers default after power-on reset
// RQ20: Reset leaves all bits one, channels idle
// RQ21: Input word holds 2-bit mode per channel
// RQ22: Output word interleaves open-load and fault flags
// RQ23: Error flag reflects previous transfer result
// RQ24: Bad frame keeps input, sets error flag
// RQ25: Flags cross into serial domain safely
`timescale 1ns/1ps

module rdsd_spi_diag
   import rdsd_pkg::*;
#(
   parameter int OL_CYC  = OPEN_LOAD_DELAY_CYC,
   parameter int OVL_CYC = OVERLOAD_OFF_DELAY_CYC
) (
   input  wire logic              clock_i,
   input  wire logic              reset_n_i,
   input  wire logic              spi_clk_i,
   input  wire logic              spi_cs_n_i,
   input  wire logic              spi_si_i,
   output logic                   spi_so_o,
   output logic                   spi_so_oe_n_o,
   input  wire logic [NUM_CH-1:0] ch_input_i,
   input  wire logic [NUM_CH-1:0] overload_i,
   input  wire logic [NUM_CH-1:0] overtemp_i,
   input  wire logic [NUM_CH-1:0] open_load_i,
   output logic      [NUM_CH-1:0] channel_on_o,
   output logic      [NUM_CH-1:0] channel_fault_flag_o,
   output logic      [NUM_CH-1:0] open_load_flag_o,
   output logic      [WORD_W-1:0] channel_mode_o,
   output logic                   transfer_error_flag_o,
   output logic                   sleep_o
);

   function automatic logic [1:0] mode_of(input logic [WORD_W-1:0] w,
                                          input int ch);
      mode_of = w[ch*MODE_W +: MODE_W];
   endfunction

   // Delay counters trip on the last cycle of their window
   function automatic logic at_limit(input logic [DELAY_CNT_W-1:0] cnt,
                                     input int                     lim);
      at_limit = (cnt == DELAY_CNT_W'(lim - 1));
   endfunction

   // ---------------- System clock domain ----------------

   logic                  cs_meta_r;
   logic                  cs_sync_r;
   logic                  cs_prev_r;
   logic [4*NUM_CH-1:0]   pin_meta_r;
   logic [4*NUM_CH-1:0]   pin_sync_r;
   logic [NUM_CH-1:0]     in_s;
   logic [NUM_CH-1:0]     ovl_s;
   logic [NUM_CH-1:0]     ot_s;
   logic [NUM_CH-1:0]     ol_s;
   logic [WORD_W-1:0]     mode_r;
   logic [NUM_CH-1:0]     fault_r;
   logic [NUM_CH-1:0]     ol_flag_r;
   logic [NUM_CH-1:0]     on_r;
   logic [NUM_CH-1:0]     on_nxt;
   logic [NUM_CH-1:0]     standby;
   logic [NUM_CH-1:0]     off_cmd;
   logic [NUM_CH-1:0]     ovl_trip;
   logic [NUM_CH-1:0]     ol_trip;
   logic [DELAY_CNT_W-1:0] ovl_cnt_r [NUM_CH];
   logic [DELAY_CNT_W-1:0] ol_cnt_r  [NUM_CH];
   logic [WORD_W-1:0]     diag_hold_r;
   logic [WORD_W-1:0]     diag_word;

   // Link side signals read here
   logic [WORD_W-1:0]     in_word_r;
   logic                  ter_r;

   // Chip select is a pin: two flops before anything looks at it
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cs_meta_r <= 1'h1;
         cs_sync_r <= 1'h1;
         cs_prev_r <= 1'h1;
      end else begin
         cs_meta_r <= spi_cs_n_i;
         cs_sync_r <= cs_meta_r;
         cs_prev_r <= cs_sync_r;
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= {open_load_i, overtemp_i, overload_i, ch_input_i};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign in_s  = pin_sync_r[0*NUM_CH +: NUM_CH];
   assign ovl_s = pin_sync_r[1*NUM_CH +: NUM_CH];
   assign ot_s  = pin_sync_r[2*NUM_CH +: NUM_CH];
   assign ol_s  = pin_sync_r[3*NUM_CH +: NUM_CH];

   // Input word was committed on the select rising edge; it is stable by
   // the time the synchronised select rises here.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_r <= IN_WORD_RESET;                            // [RQ20]
      end else if (cs_sync_r && !cs_prev_r) begin
         mode_r <= in_word_r;                                // [RQ25]
      end
   end

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         standby[c] = (mode_of(mode_r, c) == MODE_STANDBY);  // [RQ21]
         off_cmd[c] = (mode_of(mode_r, c) == MODE_OFF) ||
                      ((mode_of(mode_r, c) == MODE_INPUT) && !in_s[c]);
         ovl_trip[c] = on_r[c] && ovl_s[c] &&
                       at_limit(ovl_cnt_r[c], OVL_CYC);
         ol_trip[c]  = off_cmd[c] && ol_s[c] &&
                       at_limit(ol_cnt_r[c], OL_CYC);
         on_nxt[c]  = !standby[c] && !off_cmd[c] && !fault_r[c] &&
                      !ot_s[c] && !ovl_trip[c];              // [RQ6] [RQ7]
      end
   end

   // Channel drives only when mode, pins and the fault flag all allow it; the open-load flag does not gate it
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         on_r <= '0;
      end else begin
         on_r <= on_nxt;
      end
   end

   // Overload must persist while the channel conducts
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            ovl_cnt_r[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (on_r[c] && ovl_s[c] && !ovl_trip[c]) begin
               ovl_cnt_r[c] <= ovl_cnt_r[c] + 1'h1;        // [RQ7]
            end else begin
               ovl_cnt_r[c] <= '0;
            end
         end
      end
   end

   // Standby disables the diagnosis current, so no detection there
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int c = 0; c < NUM_CH; c++) begin
            ol_cnt_r[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (off_cmd[c] && ol_s[c] && !ol_trip[c]) begin
               ol_cnt_r[c] <= ol_cnt_r[c] + 1'h1;          // [RQ4] [RQ5]
            end else begin
               ol_cnt_r[c] <= '0;
            end
         end
      end
   end

   // A new event beats a standby clear in the same cycle
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_r <= DIAG_RESET[NUM_CH-1:0];                  // [RQ20]
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (ot_s[c] || ovl_trip[c]) begin
               fault_r[c] <= 1'h1;                  // [RQ1] [RQ6] [RQ7]
            end else if (standby[c]) begin
               fault_r[c] <= 1'h0;                           // [RQ3]
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ol_flag_r <= DIAG_RESET[NUM_CH-1:0];                // [RQ20]
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (ol_trip[c]) begin
               ol_flag_r[c] <= 1'h1;                         // [RQ2] [RQ5]
            end else if (standby[c]) begin
               ol_flag_r[c] <= 1'h0;                         // [RQ3]
            end
         end
      end
   end

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         diag_word[2*c + DIAG_FAULT_POS] = fault_r[c];       // [RQ22]
         diag_word[2*c + DIAG_OL_POS]    = ol_flag_r[c];
      end
   end

   // Snapshot frozen while select is low, so the serial side reads a
   // stable word without a per-bit synchroniser.
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         diag_hold_r <= DIAG_RESET;
      end else if (cs_sync_r) begin
         diag_hold_r <= diag_word;                           // [RQ25]
      end
   end

   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         channel_fault_flag_o <= DIAG_RESET[NUM_CH-1:0];
         open_load_flag_o     <= DIAG_RESET[NUM_CH-1:0];
         channel_on_o         <= '0;
         channel_mode_o       <= IN_WORD_RESET;
         sleep_o              <= 1'h0;
         transfer_error_flag_o <= TER_RESET;
      end else begin
         channel_fault_flag_o <= fault_r;
         open_load_flag_o     <= ol_flag_r;
         channel_on_o         <= on_r;
         channel_mode_o       <= mode_r;
         sleep_o              <= &standby;
         if (cs_sync_r && !cs_prev_r) begin
            transfer_error_flag_o <= ter_r;
         end
      end
   end

   // ---------------- Serial clock domain ----------------

   logic [2:0]        bit_cnt_r;
   logic [1:0]        oct_cnt_r;
   logic [WORD_W-1:0] rx_r;
   logic [WORD_W-1:0] tx_r;
   logic [4:0]        tx_left_r;
   logic              risen_r;
   logic              so_r;
   logic              frame_ok;
   logic              frame_clr;

   // Select high or reset clears all per-frame state
   assign frame_clr = spi_cs_n_i || !reset_n_i;

   // Counters die with the frame: select high clears them
   always_ff @(negedge spi_clk_i or posedge frame_clr) begin
      if (frame_clr) begin
         bit_cnt_r <= '0;                             // [RQ8] [RQ19]
         oct_cnt_r <= '0;
      end else begin
         bit_cnt_r <= bit_cnt_r + 1'h1;
         if (bit_cnt_r == 3'h7 && oct_cnt_r != 2'(FRAME_MIN_MULT)) begin
            oct_cnt_r <= oct_cnt_r + 1'h1;
         end
      end
   end

   always_ff @(negedge spi_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_r <= IN_WORD_RESET;                              // [RQ19]
      end else if (!spi_cs_n_i) begin
         rx_r <= {rx_r[WORD_W-2:0], spi_si_i};      // [RQ9] [RQ10] [RQ17]
      end
   end

   // First rising edge takes the frozen snapshot; after the own word the
   // received bits follow, which is what carries a chain along.
   always_ff @(posedge spi_clk_i or posedge frame_clr) begin
      if (frame_clr) begin
         risen_r   <= 1'h0;
         so_r      <= 1'h0;
         tx_r      <= '0;
         tx_left_r <= '0;
      end else if (!risen_r) begin
         risen_r   <= 1'h1;
         so_r      <= diag_hold_r[WORD_W-1];                 // [RQ11]
         tx_r      <= {diag_hold_r[WORD_W-2:0], 1'h0};
         tx_left_r <= 5'(WORD_W - 1);
      end else begin
         if (tx_left_r == 5'h0) begin
            so_r <= rx_r[WORD_W-1];                          // [RQ17]
         end else begin
            so_r      <= tx_r[WORD_W-1];                     // [RQ10]
            tx_left_r <= tx_left_r - 1'h1;
         end
         tx_r <= {tx_r[WORD_W-2:0], 1'h0};                   // [RQ9]
      end
   end

   assign frame_ok = (bit_cnt_r == 3'h0) &&
                     (oct_cnt_r == 2'(FRAME_MIN_MULT));      // [RQ14]

   // Commit on select rising; reads the counters before their clear
   always_ff @(posedge spi_cs_n_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         in_word_r <= IN_WORD_RESET;                         // [RQ19]
         ter_r     <= TER_RESET;                             // [RQ13]
      end else if (frame_ok) begin
         in_word_r <= rx_r;                                  // [RQ14]
         ter_r     <= 1'h0;                                  // [RQ23]
      end else begin
         ter_r     <= 1'h1;                                  // [RQ24]
      end
   end

   // Error indication must reach the master before any clock edge
   assign spi_so_o      = risen_r ? so_r : (ter_r | spi_si_i); // [RQ12]
   assign spi_so_oe_n_o = spi_cs_n_i;                          // [RQ8]

endmodule

/* tb/rdsd_spi_diag_asserts.sv */
// Concurrent checks on the ports of the relay driver serial block.
// Assumes a bind to rdsd_spi_diag; sees nothing but its ports.
`timescale 1ns/1ps
module rdsd_spi_diag_asserts
   import rdsd_pkg::*;
#(
   parameter int OL_CYC  = OPEN_LOAD_DELAY_CYC,
   parameter int OVL_CYC = OVERLOAD_OFF_DELAY_CYC
) (
   input wire logic              clock_i,
   input wire logic              reset_n_i,
   input wire logic              spi_clk_i,
   input wire logic              spi_cs_n_i,
   input wire logic              spi_si_i,
   input wire logic              spi_so_o,
   input wire logic              spi_so_oe_n_o,
   input wire logic [NUM_CH-1:0] overload_i,
   input wire logic [NUM_CH-1:0] overtemp_i,
   input wire logic [NUM_CH-1:0] open_load_i,
   input wire logic [NUM_CH-1:0] channel_on_o,
   input wire logic [NUM_CH-1:0] channel_fault_flag_o,
   input wire logic [NUM_CH-1:0] open_load_flag_o,
   input wire logic [WORD_W-1:0] channel_mode_o,
   input wire logic              transfer_error_flag_o
);
   logic [7:0]  bits_r;
   logic [15:0] word_r;
   logic        good_r;
   logic        rise_r;
   int          ovl_r;
   int          ol_r;
   // Old count is read at the select edge before the async clear lands
   always_ff @(negedge spi_clk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         bits_r <= 8'h00;
      end else begin
         bits_r <= bits_r + 8'h01;
         word_r <= {word_r[14:0], spi_si_i};
      end
   end
   always_ff @(posedge spi_cs_n_i or negedge reset_n_i) begin
      if (!reset_n_i) good_r <= 1'h0;
      else good_r <= (bits_r[2:0] == 3'h0) && (bits_r >= 8'h10);
   end
   always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) rise_r <= 1'h0;
      else rise_r <= 1'h1;
   end
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) ovl_r <= 0;
      else ovl_r <= overload_i[0] ? ovl_r + 1 : 0;
   end
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) ol_r <= 0;
      else ol_r <= open_load_i[2] ? ol_r + 1 : 0;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   a_oe_follows_cs: assert property (
      spi_so_oe_n_o == spi_cs_n_i) else $error("output enable off select");
   a_so_first_bit: assert property (
      !spi_cs_n_i && !rise_r |->
      spi_so_o == (transfer_error_flag_o | spi_si_i))
      else $error("first output bit wrong");
   a_good_commit: assert property (
      $rose(spi_cs_n_i) && good_r |-> ##5
      channel_mode_o == word_r && !transfer_error_flag_o)
      else $error("good frame not applied");
   a_bad_keeps: assert property (
      $rose(spi_cs_n_i) && !good_r |=> $stable(channel_mode_o)[*5]
      ##0 transfer_error_flag_o) else $error("bad frame not refused");
   a_ovl_delay: assert property (
      $rose(channel_fault_flag_o[0]) |-> ovl_r >= OVL_CYC)
      else $error("overload fault too early");
   a_fault_off: assert property (
      (channel_on_o & $past(channel_fault_flag_o)) == 8'h00)
      else $error("faulted channel still on");
   a_ol_delay: assert property (
      $rose(open_load_flag_o[2]) |-> ol_r >= OL_CYC)
      else $error("open load flag too early");
   a_ol_not_on: assert property (
      (channel_mode_o[1:0] == MODE_ON)[*3] |-> !$rose(open_load_flag_o[0]))
      else $error("open load seen while on");
   a_standby_clear: assert property (
      (channel_mode_o[1:0] == MODE_STANDBY && !overload_i[0] && !overtemp_i[0]
      && !open_load_i[0])[*4] |-> !channel_fault_flag_o[0]
      && !open_load_flag_o[0]) else $error("standby kept flags");
   c_good: cover property ($rose(spi_cs_n_i) && good_r);
   c_bad: cover property ($rose(spi_cs_n_i) && !good_r);
   c_ovl: cover property ($rose(channel_fault_flag_o[0]));
endmodule

/* tb/rdsd_spi_master.sv */
// Serial master model; one frame per call, link clock only inside frames.
// Assumes the bench spaces frames so the mode word is applied between.
`timescale 1ns/1ps
module rdsd_spi_master (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      si_o,
   input  wire logic so_i
);
   initial begin
      sclk_o = 1'h0;
      cs_n_o = 1'h0;
      si_o   = 1'h0;
      // Raised once every process waits, so frame state starts clear
      #2ns cs_n_o = 1'h1;
   end
   task automatic xfer(input int n, input logic [31:0] tx,
                       output logic [31:0] rx, output logic first);
      rx = 32'h0000_0000;
      si_o = tx[n-1];
      cs_n_o = 1'h0; // Clock low at select edges
      #80ns;
      first = so_i;
      for (int i = n - 1; i >= 0; i--) begin
         // Data moves well clear of the sampling falling edge
         #8ns si_o = tx[i];
         #8ns sclk_o = 1'h1;
         #8ns rx = {rx[30:0], so_i};
         #8ns sclk_o = 1'h0;
      end
      #16ns cs_n_o = 1'h1; // Whole chain length shifted first
      si_o = ~si_o;
   endtask
endmodule

/* tb/test_relay_driver_spi_diag.sv */
// Self-checking bench for the relay driver serial and diagnosis block.
// Assumes rdsd_pkg, the design, checker and master model compiled first.
`timescale 1ns/1ps
module test_relay_driver_spi_diag;
   import rdsd_pkg::*;
   localparam int OL_CYC  = 20;
   localparam int OVL_CYC = 5;
   logic        clock_i, reset_n_i, sclk, cs_n, si, so, oe_n, transfer_error_flag, sleep;
   logic [7:0]  ch_in, ovl, otemp, oload, on, fault, ol;
   logic [15:0] mode;
   logic [31:0] rx;
   logic        first;
   int          fail_count = 0;
   int          comparisons = 0;
   int          cyc = 0;
   rdsd_spi_diag #(.OL_CYC(OL_CYC), .OVL_CYC(OVL_CYC)) rdsd_spi_diag_inst (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .spi_clk_i(sclk),
      .spi_cs_n_i(cs_n), .spi_si_i(si), .spi_so_o(so), .spi_so_oe_n_o(oe_n),
      .ch_input_i(ch_in), .overload_i(ovl), .overtemp_i(otemp),
      .open_load_i(oload), .channel_on_o(on), .channel_fault_flag_o(fault),
      .open_load_flag_o(ol), .channel_mode_o(mode),
      .transfer_error_flag_o(transfer_error_flag), .sleep_o(sleep));
   rdsd_spi_master rdsd_spi_master_inst (
      .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
   initial begin
      clock_i = 1'h0;
      forever #10 clock_i = ~clock_i;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [39:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // Ten system clocks let the mode word and error copy settle
   task automatic frame(input int n, input logic [31:0] tx);
      rdsd_spi_master_inst.xfer(n, tx, rx, first);
      tick(10);
   endtask
   initial begin
      reset_n_i = 1'h1;
      ch_in = 8'h08;
      {ovl, otemp, oload} = 24'h00_0000;
      #1;
      reset_n_i = 1'h0;
      tick(8);
      reset_n_i = 1'h1;
      tick(3);
      frame(16, 32'h0000_0000);
      chk(first, 1'h1, "error bit after reset");
      chk(rx, 32'h0000_FFFF, "reset diagnosis");
      chk(mode, 16'h0000, "standby word");
      chk({fault, ol}, 16'h0000, "flags cleared");
      chk({transfer_error_flag, sleep}, 2'h1, "status after good frame");
      chk(oe_n, 1'h1, "output released");
      frame(16, 32'h0000_007A);
      chk(first, 1'h0, "error bit clear");
      chk(rx, 32'h0000_0000, "clean diagnosis");
      chk({mode, on}, 24'h00_7A0B, "modes applied");
      {ovl[0], otemp[1], oload[2], oload[0]} = 4'hF;
      tick(OL_CYC + 20);
      chk({fault, on, ol}, 24'h03_0804, "protection");
      {ovl, otemp, oload} = 24'h00_0000;
      tick(5);
      frame(12, 32'h0000_0FFF);
      chk(rx, 32'h0000_0002, "short frame data");
      chk({transfer_error_flag, mode}, 17'h1_007A, "short frame refused");
      frame(24, 32'h0055_0000);
      chk(first, 1'h1, "error after refusal");
      chk(rx, 32'h0000_2555, "chained data");
      chk({transfer_error_flag, mode, fault, ol}, 33'h0, "chained standby");
      tally_and_finish();
   end
endmodule
bind rdsd_spi_diag rdsd_spi_diag_asserts #(.OL_CYC(OL_CYC),
   .OVL_CYC(OVL_CYC)) rdsd_spi_diag_asserts_inst (.*);
